// [core/rtca_pkg.sv]
// Constants and types shared by the serial read target and its bench.
// Assumes one 250 MHz system clock; the bus pins are asynchronous to it.
package rtca_pkg;

   localparam int CLK_PERIOD_NS = 4;
   localparam int TIMEOUT_MS    = 500;
   localparam int TIMEOUT_CYC   = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TMO_W         = 27;

   localparam int PTR_W  = 5;
   localparam int MODE_W = 3;
   localparam int BYTE_W = 8;

   // Value is arbitrary; set the real target address by parameter.
   localparam logic [6:0]       DEV_ADDR_DEF = 7'h2a;
   localparam logic [PTR_W-1:0] PTR_RESET    = 5'h00;
   localparam logic [2:0]       LAST_BIT     = 3'h7;
   localparam int               MODE_LSB     = 5;

   typedef enum logic [3:0] {
      S_IDLE,
      S_DEV,
      S_DEV_ACK,
      S_REG,
      S_REG_ACK,
      S_WR,
      S_WR_ACK,
      S_RD,
      S_RD_ACK
   } rtca_state_t;

endpackage

// [core/rtca_target.sv]
// Two-wire serial target: addressed and current-address reads, access hold.
// Assumes the register file answers reg_rdata combinationally for reg_addr
// on mclk, and that sda/scl pins are synchronised here.
//
// Overview of operation
// - After Sr, target address with read bit is acknowledged; read begins.
// - After that acknowledge, data bytes leave MSB first, one bit per clock.
// - A master acknowledge on the ninth bit makes the next byte follow.
// - A master not-acknowledge ends the read and releases the data line.
// - Register pointer advances by one after each byte transferred.
// - Pointer resets to 00h, so the first plain read after reset starts at register 00h.
// - Carries into clock registers are held from start until stop.
// - Half a second after start the access is forcibly ended.
// - A repeated start does not restart the half-second timeout.
// - Register byte: low five bits address, upper three bits mode.
`timescale 1ns/10ps
module rtca_target #(
   parameter int         TIMEOUT_CYC_P = rtca_pkg::TIMEOUT_CYC,
   parameter logic [6:0] DEV_ADDR      = rtca_pkg::DEV_ADDR_DEF
) (
   input  wire logic                         mclk,
   input  wire logic                         reset,
   input  wire logic                         scl_i,
   input  wire logic                         sda_i,
   output logic                              sda_o,
   output logic                              sda_oe,
   output logic [rtca_pkg::PTR_W-1:0]        reg_addr,
   input  wire logic [rtca_pkg::BYTE_W-1:0]  reg_rdata,
   output logic                              rd_en,
   output logic [rtca_pkg::BYTE_W-1:0]       wr_data,
   output logic                              wr_en,
   output logic [rtca_pkg::MODE_W-1:0]       xfer_mode,
   output logic                              count_hold
);
   import rtca_pkg::*;

   typedef struct packed {
      logic                scl_s1;
      logic                scl_s2;
      logic                scl_d;
      logic                sda_s1;
      logic                sda_s2;
      logic                sda_d;
      rtca_state_t         st;
      logic [2:0]          bitcnt;
      logic                phase;
      logic                rw;
      logic                mack;
      logic [BYTE_W-1:0]   shreg;
      logic [PTR_W-1:0]    ptr;
      logic [MODE_W-1:0]   mode;
      logic                sda_oe;
      logic                hold;
      logic [TMO_W-1:0]    tmo_cnt;
      logic                rd_en;
      logic                wr_en;
   } rtca_regs_t;

   rtca_regs_t r_reg;
   rtca_regs_t r_next;

   logic              start_det;
   logic              stop_det;
   logic              scl_rise;
   logic              scl_fall;
   logic              tmo_hit;
   logic [BYTE_W-1:0] in_byte;

   // Edges are taken only from the second synchroniser stage onward.
   assign start_det = r_reg.scl_s2 & r_reg.sda_d & ~r_reg.sda_s2;
   assign stop_det  = r_reg.scl_s2 & ~r_reg.sda_d & r_reg.sda_s2;
   assign scl_rise  = r_reg.scl_s2 & ~r_reg.scl_d;
   assign scl_fall  = ~r_reg.scl_s2 & r_reg.scl_d;
   assign tmo_hit   = r_reg.tmo_cnt == TMO_W'(TIMEOUT_CYC_P - 1);
   assign in_byte   = {r_reg.shreg[BYTE_W-2:0], r_reg.sda_s2};

   always_comb begin
      r_next        = r_reg;
      r_next.rd_en  = 1'b0;
      r_next.wr_en  = 1'b0;
      r_next.scl_s1 = scl_i;
      r_next.scl_s2 = r_reg.scl_s1;
      r_next.scl_d  = r_reg.scl_s2;
      r_next.sda_s1 = sda_i;
      r_next.sda_s2 = r_reg.sda_s1;
      r_next.sda_d  = r_reg.sda_s2;
      if (r_reg.hold) begin
         r_next.tmo_cnt = r_reg.tmo_cnt + 1'b1;
      end
      if (r_reg.hold && tmo_hit) begin
         // A stuck master must not freeze the time count for ever.
         r_next.hold   = 1'b0;
         r_next.st     = S_IDLE;
         r_next.sda_oe = 1'b0;
      end else if (start_det) begin
         r_next.st     = S_DEV;
         r_next.bitcnt = '0;
         r_next.phase  = 1'b0;
         r_next.sda_oe = 1'b0;
         if (!r_reg.hold) begin
            r_next.hold    = 1'b1;
            r_next.tmo_cnt = '0;
         end
      end else if (stop_det) begin
         r_next.st     = S_IDLE;
         r_next.hold   = 1'b0;
         r_next.sda_oe = 1'b0;
      end else if (scl_rise) begin
         unique case (r_reg.st)
            S_DEV, S_REG, S_WR: begin
               r_next.shreg  = in_byte;
               r_next.bitcnt = r_reg.bitcnt + 1'b1;
               if (r_reg.bitcnt == LAST_BIT) begin
                  r_next.phase = 1'b0;
                  if (r_reg.st == S_DEV) begin
                     if (r_reg.shreg[6:0] == DEV_ADDR) begin
                        r_next.rw = r_reg.sda_s2;
                        r_next.st = S_DEV_ACK;
                     end else begin
                        r_next.st = S_IDLE;
                     end
                  end else if (r_reg.st == S_REG) begin
                     r_next.ptr  = in_byte[PTR_W-1:0];
                     r_next.mode = in_byte[BYTE_W-1:MODE_LSB];
                     r_next.st   = S_REG_ACK;
                  end else begin
                     r_next.wr_en = 1'b1;
                     r_next.st    = S_WR_ACK;
                  end
               end
            end
            S_RD: begin
               r_next.bitcnt = r_reg.bitcnt + 1'b1;
               if (r_reg.bitcnt == LAST_BIT) begin
                  r_next.ptr   = r_reg.ptr + 1'b1;
                  r_next.phase = 1'b0;
                  r_next.st    = S_RD_ACK;
               end
            end
            S_RD_ACK: begin
               r_next.mack = ~r_reg.sda_s2;
            end
            S_IDLE, S_DEV_ACK, S_REG_ACK, S_WR_ACK: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (r_reg.st)
            S_DEV_ACK, S_REG_ACK, S_WR_ACK: begin
               if (!r_reg.phase) begin
                  r_next.sda_oe = 1'b1;
                  r_next.phase  = 1'b1;
               end else begin
                  r_next.sda_oe = 1'b0;
                  r_next.phase  = 1'b0;
                  if (r_reg.st == S_DEV_ACK && r_reg.rw) begin
                     r_next.shreg  = reg_rdata;
                     r_next.sda_oe = ~reg_rdata[BYTE_W-1];
                     r_next.rd_en  = 1'b1;
                     r_next.st     = S_RD;
                  end else if (r_reg.st == S_DEV_ACK) begin
                     r_next.st = S_REG;
                  end else if (r_reg.st == S_REG_ACK) begin
                     r_next.st = S_WR;
                  end else begin
                     r_next.ptr = r_reg.ptr + 1'b1;
                     r_next.st  = S_WR;
                  end
               end
            end
            S_RD: begin
               r_next.shreg  = r_reg.shreg << 1;
               r_next.sda_oe = ~r_reg.shreg[BYTE_W-2];
            end
            S_RD_ACK: begin
               if (!r_reg.phase) begin
                  r_next.sda_oe = 1'b0;
                  r_next.phase  = 1'b1;
               end else if (r_reg.mack) begin
                  r_next.shreg  = reg_rdata;
                  r_next.sda_oe = ~reg_rdata[BYTE_W-1];
                  r_next.rd_en  = 1'b1;
                  r_next.phase  = 1'b0;
                  r_next.st     = S_RD;
               end else begin
                  r_next.sda_oe = 1'b0;
                  r_next.st     = S_IDLE;
               end
            end
            S_IDLE, S_DEV, S_REG, S_WR: begin
            end
         endcase
      end
   end

   // Synchronisers reset high so a released bus shows no false start.
   always_ff @(posedge mclk) begin
      if (reset) begin
         r_reg        <= '0;
         r_reg.scl_s1 <= 1'b1;
         r_reg.scl_s2 <= 1'b1;
         r_reg.scl_d  <= 1'b1;
         r_reg.sda_s1 <= 1'b1;
         r_reg.sda_s2 <= 1'b1;
         r_reg.sda_d  <= 1'b1;
         r_reg.st     <= S_IDLE;
         r_reg.ptr    <= PTR_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sda_o      = 1'b0;
   assign sda_oe     = r_reg.sda_oe;
   assign reg_addr   = r_reg.ptr;
   assign rd_en      = r_reg.rd_en;
   assign wr_data    = r_reg.shreg;
   assign wr_en      = r_reg.wr_en;
   assign xfer_mode  = r_reg.mode;
   assign count_hold = r_reg.hold;

endmodule

// [verification/rtc_serial_read_and_access_timeout_bench.sv]
// Bench for the serial read target with a master model on the bus.
// Assumes a register file whose data is the pointer with a fixed tail.
`timescale 1ns/10ps
module rtc_serial_read_and_access_timeout_bench;
   import rtca_pkg::*;
   localparam int TMO = 2000;
   logic       mclk = 1'b0;
   logic       reset = 1'b1;
   logic       scl, sda_m, sda_o, sda_oe, rd_en, wr_en, count_hold, a;
   logic [4:0] reg_addr;
   logic [7:0] wr_data, q, wr_seen;
   logic [2:0] xfer_mode;
   int         err_total = 0, total_checks = 0, cyc = 0, c0, rd_cnt = 0;
   wire        sda = sda_m & ~sda_oe;
   wire [7:0]  reg_rdata = {reg_addr, 3'h6};
   always #2 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   always @(posedge mclk) begin
      if (rd_en) rd_cnt <= rd_cnt + 1;
      if (wr_en) wr_seen <= wr_data;
   end
   rtca_target #(.TIMEOUT_CYC_P(TMO), .DEV_ADDR(DEV_ADDR_DEF)) dut (
      .mclk, .reset, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .reg_addr,
      .reg_rdata, .rd_en, .wr_data, .wr_en, .xfer_mode, .count_hold);
   rtca_master m (.mclk, .scl, .sda_m, .sda);
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic addr(input logic rd);
      m.xfer({DEV_ADDR_DEF, rd}, 1'b1, q, a);
      chk("addr ack", a, 8'h00);
   endtask
   task automatic rd_bytes(input logic [4:0] p, input int n);
      for (int k = 0; k < n; k++) begin
         m.xfer(8'hff, k == n - 1, q, a);
         chk("rdata", q, {5'(p + 5'(k)), 3'h6});
      end
   endtask
   task automatic current_read;
      m.start(); addr(1'b1);
      chk("hold", count_hold, 8'h01);
      rd_bytes(5'h00, 3);
      chk("loads", 8'(rd_cnt), 8'h03);
      m.stop(); m.w(8);
      chk("hold end", count_hold, 8'h00);
      chk("released", sda_oe, 8'h00);
   endtask
   task automatic addr_read;
      m.start(); addr(1'b0);
      m.xfer(8'ha7, 1'b1, q, a);
      chk("reg ack", a, 8'h00);
      chk("mode", xfer_mode, 8'h05);
      m.start(); addr(1'b1);
      rd_bytes(5'h07, 3);
      m.stop();
   endtask
   task automatic write_case;
      m.start();
      addr(1'b0);
      m.xfer(8'h1e, 1'b1, q, a);
      chk("wr reg ack", a, 8'h00);
      m.xfer(8'h5c, 1'b1, q, a);
      chk("wr ack", a, 8'h00);
      chk("wr data", wr_seen, 8'h5c);
      chk("wr ptr", 8'(reg_addr), 8'h1f);
      chk("wr mode", xfer_mode, 8'h00);
      m.stop();
   endtask
   task automatic timeout_case;
      c0 = cyc; m.start(); addr(1'b0);
      m.xfer(8'h00, 1'b1, q, a);
      chk("tmo reg ack", a, 8'h00);
      m.start(); addr(1'b1);
      for (int i = 0; i < TMO + 100 && count_hold; i++) m.w(1);
      chk("tmo", 8'(cyc - c0 >= TMO && cyc - c0 <= TMO + 24), 8'h01);
      chk("tmo rel", sda_oe, 8'h00);
      m.xfer(8'hff, 1'b1, q, a);
      chk("ignored", {q[7:1], a}, 8'hff);
      chk("no hold", count_hold, 8'h00);
      m.stop();
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      m.w(4);
      current_read();
      addr_read();
      write_case();
      timeout_case();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      give_verdict();
   end
endmodule

// [verification/rtca_master.sv]
// Bus master model: drives the clock line and its side of the data wire.
// Assumes the bench resolves the wire with a pull-up; clock idles high.
`timescale 1ns/10ps
module rtca_master (
   input wire logic mclk,
   output logic     scl,
   output logic     sda_m,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Also serves as repeated start, entered with the clock low.
   task automatic start;
      sda_m <= 1'b1; w(4); scl <= 1'b1; w(8);
      sda_m <= 1'b0; w(8); scl <= 1'b0; w(4);
   endtask
   task automatic stop;
      sda_m <= 1'b0; w(4); scl <= 1'b1; w(8); sda_m <= 1'b1; w(8);
   endtask
   task automatic bit_x(input logic b, output logic r);
      sda_m <= b; w(4); scl <= 1'b1; w(4); r = sda; w(4); scl <= 1'b0; w(4);
   endtask
   // A read ends with the ninth bit high, so no byte follows it.
   task automatic xfer(input logic [7:0] d, input logic ack_m,
                       output logic [7:0] q, output logic ack_s);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ack_m, ack_s);
   endtask
endmodule

// [verification/rtca_properties.sv]
// Assertions on the ports of the serial read target, bound to it.
// Assumes one clock domain and the target's synchronous reset.
`timescale 1ns/10ps
module rtca_properties #(
   parameter int TIMEOUT_CYC_P = 2000
) (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic [4:0] reg_addr,
   input wire logic       rd_en,
   input wire logic [2:0] xfer_mode,
   input wire logic       count_hold
);
   int unsigned hold_cnt_reg;
   always_ff @(posedge mclk)
      hold_cnt_reg <= (reset || !count_hold) ? 0 : hold_cnt_reg + 1;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   AST_OUT_LOW: assert property (sda_o == 1'b0)
      else $error("data value not low");
   AST_RESET: assert property (disable iff (1'b0)
      reset |=> !count_hold && !sda_oe) else $error("reset not idle");
   AST_RD_PULSE: assert property (rd_en |=> !rd_en)
      else $error("load pulse too long");
   // A register byte loads the pointer while the data line is released.
   AST_PTR_STEP: assert property (!$stable(reg_addr) |->
      count_hold && (reg_addr == $past(reg_addr) + 5'h01 || !sda_oe))
      else $error("pointer jump");
   AST_IDLE_REL: assert property (!count_hold && !$past(count_hold)
      |-> !sda_oe) else $error("data driven while idle");
   AST_TMO: assert property (count_hold |->
      hold_cnt_reg < TIMEOUT_CYC_P) else $error("hold too long");
   AST_START: assert property ($fell(sda_i) && scl_i && $past(scl_i)
      |-> ##[1:6] count_hold) else $error("start not held");
   AST_STOP: assert property ($rose(sda_i) && scl_i && $past(scl_i)
      |-> ##[1:6] !count_hold) else $error("stop not released");
   cover property (rd_en);
   cover property ($fell(count_hold));
   cover property (xfer_mode == 3'h5);
endmodule
bind rtca_target rtca_properties #(.TIMEOUT_CYC_P(TIMEOUT_CYC_P)) chk (
   .mclk, .reset, .scl_i, .sda_i, .sda_o, .sda_oe, .reg_addr, .rd_en,
   .xfer_mode, .count_hold);
